// ===== include/two_wire_regs.vh
// Register map, field positions, status codes and timing of the two-wire master receiver
// Function
// RL1: Enable, start and flag-write make the unit send START when bus free.
// RL2: After START goes out, set flag and report status 0x08.
// RL3: Software loads address-with-read, then writes flag one, enable one, start/stop zero.
// RL4: Writing one to flag clears it and runs the next bus action.
// RL5: After address-with-read and its ack slot, set flag, report 0x38/0x40/0x48.
// RL6: When flag is set after a received byte, data register holds it.
// RL7: Software clears acknowledge enable before the last byte to answer NACK.
// RL8: Flag one, stop one, start zero, enable one sends a STOP.
// RL9: Flag one, start one, stop zero gives repeated START, status 0x10.
// RL10: At 0x10, read address stays receiver; write address moves to transmitter.
// RL11: At 0x38, start zero releases bus; start one sends START when free.
// RL12: At 0x40, receive one byte, ACK or NACK per acknowledge enable.
// RL13: At 0x48, start gives repeated START, stop gives STOP, both STOP then START.
// RL14: At 0x50, receive another byte, answering per acknowledge enable.
// RL15: At 0x58, start/stop choose repeated START, STOP, or STOP then START.
// RL16: After sending a requested STOP, hardware clears the stop request bit.
// RL17: Every control write continuing a transfer keeps interface enable one.
// RL18: Repeated START keeps bus ownership between addresses and directions.
// RL19: Software masks prescaler bits of status to zero before comparing codes.
// RL20: Control bits 7..0: flag, ack enable, start, stop, collision, enable, reserved, irq enable.
// RL21: While flag is set, the unit holds the serial clock line low. The code releases the clock at status 0x38 with the flag set.
`ifndef TWO_WIRE_REGS_VH
`define TWO_WIRE_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define TW_CTRL_ADDR 4'h0
`define TW_STAT_ADDR 4'h4
`define TW_DATA_ADDR 4'h8
`define TW_IDX_CTRL 2'h0
`define TW_IDX_STAT 2'h1
`define TW_IDX_DATA 2'h2

// ****************************************
// Control fields
// ****************************************
`define TW_FLAG_BIT 7
`define TW_ACKEN_BIT 6
`define TW_STA_BIT 5
`define TW_STO_BIT 4
`define TW_WC_BIT 3
`define TW_EN_BIT 2
`define TW_IE_BIT 0

// ****************************************
// Reset values
// ****************************************
`define TW_CTRL_RESET 8'h00
`define TW_STAT_RESET 8'hf8
`define TW_DATA_RESET 8'hff

// ****************************************
// Status codes
// ****************************************
`define TW_ST_START 8'h08
`define TW_ST_RSTART 8'h10
`define TW_ST_AW_ACK 8'h18
`define TW_ST_AW_NACK 8'h20
`define TW_ST_DW_ACK 8'h28
`define TW_ST_DW_NACK 8'h30
`define TW_ST_ARB 8'h38
`define TW_ST_AR_ACK 8'h40
`define TW_ST_AR_NACK 8'h48
`define TW_ST_RX_ACK 8'h50
`define TW_ST_RX_NACK 8'h58

// ****************************************
// Timing
// ****************************************
`define TW_CLK_MHZ 10
`define TW_QUARTER_NS 200
`define TW_QUARTER_CYC ((`TW_QUARTER_NS * `TW_CLK_MHZ + 999) / 1000)

`endif

// ===== hw/two_wire_sync.v
// Two-flop synchronisers for the serial bus pin inputs
`timescale 1ns/1ps
`default_nettype none

module two_wire_sync (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Pins in, synchronised out
  input wire [1:0] pin_in,
  output wire [1:0] pin_sync
);

  reg [1:0] meta_q;
  reg [1:0] sync_q;

  // ****************************************
  // Per-pin flop pairs
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= pin_in[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_q;

endmodule

`default_nettype wire

// ===== hw/two_wire_axil.v
// AXI4-Lite slave front end for the two-wire register file
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.vh"

module two_wire_axil (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write address and data
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // Write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Register file side
  output wire wr_en,
  output wire [1:0] wr_idx,
  output wire [7:0] wr_data,
  output wire [1:0] rd_idx,
  input wire [7:0] rd_data
);

  reg aw_full_q;
  reg w_full_q;
  reg [3:0] aw_addr_q;
  reg [7:0] w_data_q;
  reg w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [7:0] rdata_q;
  wire do_write;

  // ****************************************
  // Address decode
  // ****************************************
  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `TW_CTRL_ADDR) || (addr == `TW_STAT_ADDR) ||
               (addr == `TW_DATA_ADDR);
    end
  endfunction

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_en = do_write && w_strb_q && mapped(aw_addr_q);
  assign wr_idx = aw_addr_q[3:2];
  assign wr_data = w_data_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign rd_idx = s_axi_araddr[3:2];
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h000000, rdata_q};

  // ****************************************
  // Write and read channels
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(aw_addr_q) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
        rdata_q <= mapped(s_axi_araddr) ? rd_data : 8'h00;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ===== hw/two_wire_master_rx.v
// Two-wire bus master with receiver mode, register file and bit engine
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.vh"

module two_wire_master_rx (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Serial clock pin
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  // Serial data pin
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe
);

  // ****************************************
  // States and timing
  // ****************************************
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_START = 5'b00010;
  localparam [4:0] ST_BIT = 5'b00100;
  localparam [4:0] ST_STOP = 5'b01000;
  localparam [4:0] ST_WAIT = 5'b10000;
  localparam integer QCYC = `TW_QUARTER_CYC;
  localparam [2:0] QLAST = QCYC[2:0] - 3'd1;

  wire wr_en;
  wire [1:0] wr_idx;
  wire [7:0] wr_data;
  wire [1:0] rd_idx;
  reg [7:0] rd_data;
  wire [1:0] pin_s;
  wire scl_s;
  wire sda_s;

  reg flag_q;
  reg ack_en_q;
  reg sta_q;
  reg sto_q;
  reg wc_q;
  reg en_q;
  reg ie_q;
  reg [7:0] status_q;
  reg [7:0] data_q;

  reg [4:0] st_q;
  reg [1:0] ph_q;
  reg [2:0] tq_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg tx_q;
  reg addr_q;
  reg rd_q;
  reg ack_q;
  reg own_q;
  reg busy_q;
  reg sda_prev_q;
  reg scl_low_q;
  reg sda_low_q;

  wire go;
  wire step;
  wire bit_val;
  wire [1:0] kind;

  // ****************************************
  // Sub-blocks
  // ****************************************
  two_wire_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_idx(rd_idx),
    .rd_data(rd_data)
  );

  two_wire_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({scl_i, sda_i}),
    .pin_sync(pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // ****************************************
  // Pin drive, open drain
  // ****************************************
  // RL21: clock held low
  assign scl_o = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_o = 1'b0;
  assign sda_oe = sda_low_q;

  // ****************************************
  // Next action decode
  // ****************************************
  function [1:0] code_kind;
    input [7:0] code;
    begin
      case (code)
        `TW_ST_START, `TW_ST_RSTART, `TW_ST_AW_ACK, `TW_ST_AW_NACK,
        `TW_ST_DW_ACK, `TW_ST_DW_NACK: code_kind = 2'b01;
        `TW_ST_AR_ACK, `TW_ST_RX_ACK: code_kind = 2'b10;
        default: code_kind = 2'b00;
      endcase
    end
  endfunction

  // RL4: flag clear runs engine
  assign go = en_q && !flag_q;
  assign kind = code_kind(status_q);
  // Clock stretch: count only once released clock reads high
  assign step = (tq_q == QLAST) && (scl_low_q || scl_s);
  // RL12: ack per enable
  assign bit_val = tx_q ? ((bit_q == 4'd8) ? 1'b1 : sh_q[7])
                        : ((bit_q == 4'd8) ? !ack_en_q : 1'b1);

  // ****************************************
  // Register read mux
  // ****************************************
  // RL20: control layout
  always @* begin
    case (rd_idx)
      `TW_IDX_CTRL: rd_data = {flag_q, ack_en_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
      `TW_IDX_STAT: rd_data = {status_q[7:3], 3'b000};
      `TW_IDX_DATA: rd_data = data_q;
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // Registers and bus engine
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
      ack_en_q <= 1'b0;
      sta_q <= 1'b0;
      sto_q <= 1'b0;
      wc_q <= 1'b0;
      en_q <= 1'b0;
      ie_q <= 1'b0;
      status_q <= `TW_STAT_RESET;
      data_q <= `TW_DATA_RESET;
      st_q <= ST_IDLE;
      ph_q <= 2'd0;
      tq_q <= 3'd0;
      bit_q <= 4'd0;
      sh_q <= 8'h00;
      tx_q <= 1'b0;
      addr_q <= 1'b0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      own_q <= 1'b0;
      busy_q <= 1'b0;
      sda_prev_q <= 1'b1;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      // Bus free tracking from START and STOP edges
      sda_prev_q <= sda_s;
      if (scl_s && sda_prev_q && !sda_s) begin
        busy_q <= 1'b1;
      end else if (scl_s && !sda_prev_q && sda_s) begin
        busy_q <= 1'b0;
      end
      // RL4: software writes
      if (wr_en && wr_idx == `TW_IDX_CTRL) begin
        if (wr_data[`TW_FLAG_BIT]) begin
          flag_q <= 1'b0;
        end
        ack_en_q <= wr_data[`TW_ACKEN_BIT];
        sta_q <= wr_data[`TW_STA_BIT];
        sto_q <= wr_data[`TW_STO_BIT];
        en_q <= wr_data[`TW_EN_BIT];
        ie_q <= wr_data[`TW_IE_BIT];
      end
      if (wr_en && wr_idx == `TW_IDX_DATA) begin
        if (flag_q) begin
          data_q <= wr_data;
          wc_q <= 1'b0;
        end else begin
          wc_q <= 1'b1;
        end
      end
      // Quarter-period timer
      if (st_q == ST_IDLE || st_q == ST_WAIT || step || !(scl_low_q || scl_s)) begin
        tq_q <= 3'd0;
      end else begin
        tq_q <= tq_q + 3'd1;
      end
      if (step) begin
        ph_q <= ph_q + 2'd1;
      end
      case (st_q)
        ST_IDLE: begin
          ph_q <= 2'd0;
          // RL1: start when bus free
          if (go && sta_q && !busy_q) begin
            st_q <= ST_START;
          end else if (go && sto_q) begin
            sto_q <= 1'b0;
          end
        end
        ST_WAIT: begin
          ph_q <= 2'd0;
          if (go) begin
            if (sto_q) begin
              // RL8: stop request
              st_q <= ST_STOP;
            end else if (sta_q) begin
              // RL9: repeated start
              st_q <= ST_START;
            end else if (kind != 2'b00) begin
              // RL14: next byte
              st_q <= ST_BIT;
              bit_q <= 4'd0;
              tx_q <= kind[0];
              sh_q <= data_q;
              addr_q <= (status_q == `TW_ST_START) || (status_q == `TW_ST_RSTART);
              // RL10: direction from address
              if ((status_q == `TW_ST_START) || (status_q == `TW_ST_RSTART)) begin
                rd_q <= data_q[0];
              end
            end
          end
        end
        ST_START: begin
          if (step) begin
            case (ph_q)
              2'd0: sda_low_q <= 1'b0;
              2'd1: scl_low_q <= 1'b0;
              2'd2: sda_low_q <= 1'b1;
              default: begin
                scl_low_q <= 1'b1;
                st_q <= ST_WAIT;
                flag_q <= 1'b1;
                // RL2: start status
                // RL18: ownership kept
                status_q <= own_q ? `TW_ST_RSTART : `TW_ST_START;
                own_q <= 1'b1;
              end
            endcase
          end
        end
        ST_STOP: begin
          if (step) begin
            case (ph_q)
              2'd0: sda_low_q <= 1'b1;
              2'd1: scl_low_q <= 1'b0;
              2'd2: sda_low_q <= 1'b0;
              default: begin
                // RL16: stop bit cleared
                // RL13: start may follow
                sto_q <= 1'b0;
                own_q <= 1'b0;
                st_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_BIT: begin
          if (step) begin
            case (ph_q)
              2'd0: sda_low_q <= !bit_val;
              2'd1: scl_low_q <= 1'b0;
              2'd2: begin
                if (!sda_low_q && !sda_s && (tx_q ? bit_q != 4'd8 : bit_q == 4'd8)) begin
                  // RL11: arbitration lost
                  st_q <= ST_IDLE;
                  flag_q <= 1'b1;
                  status_q <= `TW_ST_ARB;
                  own_q <= 1'b0;
                  scl_low_q <= 1'b0;
                  sda_low_q <= 1'b0;
                end else if (bit_q == 4'd8) begin
                  ack_q <= !sda_s;
                end else begin
                  sh_q <= {sh_q[6:0], sda_s};
                end
              end
              default: begin
                scl_low_q <= 1'b1;
                if (bit_q == 4'd8) begin
                  st_q <= ST_WAIT;
                  flag_q <= 1'b1;
                  // RL6: byte ready with flag
                  if (!tx_q) begin
                    data_q <= sh_q;
                  end
                  // RL5: address status
                  // RL15: nack status
                  if (!tx_q) begin
                    status_q <= ack_q ? `TW_ST_RX_ACK : `TW_ST_RX_NACK;
                  end else if (addr_q && rd_q) begin
                    status_q <= ack_q ? `TW_ST_AR_ACK : `TW_ST_AR_NACK;
                  end else if (addr_q) begin
                    status_q <= ack_q ? `TW_ST_AW_ACK : `TW_ST_AW_NACK;
                  end else begin
                    status_q <= ack_q ? `TW_ST_DW_ACK : `TW_ST_DW_NACK;
                  end
                end else begin
                  bit_q <= bit_q + 4'd1;
                end
              end
            endcase
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      // Disabled unit lets go of the bus
      if (!en_q) begin
        st_q <= ST_IDLE;
        own_q <= 1'b0;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ===== verification/two_wire_master_rx_properties.sv
// Assertions on the register bus and open-drain pins of the two-wire master
`timescale 1ns/1ps
`default_nettype none

module two_wire_master_rx_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pin enables
  input wire logic scl_oe,
  input wire logic sda_oe
);
  // ****************************************
  // Hold and write age counters
  // ****************************************
  logic [5:0] hold_q;
  logic [5:0] age_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 6'h00;
      age_q <= 6'h3f;
    end else begin
      hold_q <= !scl_oe ? 6'h00 : (hold_q == 6'h3f ? hold_q : hold_q + 6'h01);
      age_q <= ((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready)) ? 6'h00 :
        (age_q == 6'h3f ? age_q : age_q + 6'h01);
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_write_answer: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_write_retire: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write response not retired");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read data missing");
  chk_read_retire: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not retired");
  chk_busy_refuse: assert property (
    s_axi_bvalid || s_axi_rvalid |-> !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready))
    else $error("request taken while busy");
  chk_start_cond: assert property (
    !scl_oe && $rose(sda_oe) |-> ##[1:3] (scl_oe && sda_oe))
    else $error("start condition malformed");
  chk_stop_cond: assert property (
    $fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> !$past(scl_oe, 2))
    else $error("stop condition malformed");
  chk_hold_low: assert property (
    $fell(scl_oe) |-> hold_q <= 6'd6 || age_q <= 6'd12)
    else $error("clock line released without software");
endmodule

bind two_wire_master_rx two_wire_master_rx_props chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .scl_oe, .sda_oe);
`default_nettype wire

// ===== verification/slave_tx_model.sv
// Behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ps
`default_nettype none

module slave_tx_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter logic [7:0] FIRST_BYTE = 8'hc3
) (
  // Bus levels
  input wire logic scl,
  input wire logic sda,
  // Pulls, high drives low
  output logic sda_pull,
  output logic scl_pull,
  // Clock stretch after each fall
  input wire logic [11:0] stretch_ns
);
  logic [1:0] mode;
  logic [3:0] bit_n;
  logic [7:0] sh;
  logic [7:0] tx;
  logic hit;
  logic acked;
  initial begin
    {mode, bit_n, sh, tx, hit, acked, sda_pull, scl_pull} = '0;
  end
  // ****************************************
  // Framing, sampling and shifting
  // ****************************************
  always @(negedge sda) if (scl === 1'b1) begin
    mode = 2'd1;
    bit_n = 4'hf;
    sda_pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) mode = 2'd0;
  always @(posedge scl) begin
    if (mode == 2'd1 && bit_n < 4'd8) sh = {sh[6:0], sda};
    if (mode == 2'd2 && bit_n == 4'd8) acked = !sda;
  end
  always @(negedge scl) begin
    if (mode != 2'd0) bit_n = bit_n + 4'd1;
    if (mode == 2'd1 && bit_n == 4'd8) begin
      hit = (sh[7:1] == DEV_ADDR) && sh[0];
      sda_pull = hit;
    end else if (mode == 2'd1 && bit_n == 4'd9) begin
      mode = hit ? 2'd2 : 2'd0;
      bit_n = 4'd0;
      tx = FIRST_BYTE;
      sda_pull = hit && !tx[7];
    end else if (mode == 2'd2 && bit_n < 4'd8) begin
      sda_pull = !tx[3'd7 - bit_n[2:0]];
    end else if (mode == 2'd2 && bit_n == 4'd8) begin
      sda_pull = 1'b0;
    end else if (mode == 2'd2) begin
      bit_n = 4'd0;
      tx = tx + 8'h11;
      sda_pull = acked && !tx[7];
      mode = acked ? 2'd2 : 2'd0;
    end
    if (stretch_ns != 12'd0) begin
      scl_pull = 1'b1;
      #(stretch_ns);
      scl_pull = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the two-wire master receiver
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.vh"

module testbench;
  // ****************************************
  // Signals, design and bus
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic scl_o, scl_oe, sda_o, sda_oe, sda_pull, scl_pull;
  logic [11:0] stretch_ns = 12'h000;
  int failures = 0;
  int cmp_count = 0;
  wire logic scl_i = (scl_oe ? scl_o : 1'b1) & !scl_pull;
  wire logic sda_i = (sda_oe ? sda_o : 1'b1) & !sda_pull;
  always #50 aclk = ~aclk;
  two_wire_master_rx dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);
  slave_tx_model slave_u (.scl(scl_i), .sda(sda_i), .sda_pull, .scl_pull, .stretch_ns);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] er);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      if (!a_ok && s_axi_awready === 1'b1) begin a_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w_ok && s_axi_wready === 1'b1) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic poll_ctrl(input int bit_i, input logic want, output logic [31:0] v);
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      axi_rd(`TW_CTRL_ADDR, v, r);
      n++;
    end while (v[bit_i] !== want && n < 500);
  endtask
  task automatic step(input logic [8:0] ld, input logic [7:0] ctl, input logic [7:0] st,
      input logic [8:0] dv);
    logic [31:0] v;
    logic [1:0] r;
    if (ld[8]) axi_wr(`TW_DATA_ADDR, ld[7:0], 2'b00);
    axi_wr(`TW_CTRL_ADDR, ctl, 2'b00);
    poll_ctrl(`TW_FLAG_BIT, 1'b1, v);
    check(v[`TW_FLAG_BIT], 1'b1);
    check(scl_i, 1'b0);
    axi_rd(`TW_STAT_ADDR, v, r);
    check(v & 32'hf8, {24'h0, st});
    if (dv[8]) begin
      axi_rd(`TW_DATA_ADDR, v, r);
      check(v, {24'h0, dv[7:0]});
    end
  endtask
  // ****************************************
  // Test sequence and watchdog
  // ****************************************
  initial begin
    #(4000000);
    failures++;
    finish_test();
  end
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`TW_CTRL_ADDR, v, r);
    check(v, {24'h0, `TW_CTRL_RESET});
    axi_rd(`TW_STAT_ADDR, v, r);
    check(v, {24'h0, `TW_STAT_RESET});
    axi_rd(`TW_DATA_ADDR, v, r);
    check(v, {24'h0, `TW_DATA_RESET});
    axi_rd(4'hc, v, r);
    check(v, 32'h0);
    check({30'h0, r}, 32'h2);
    axi_wr(4'hc, 8'h12, 2'b10);
    s_axi_wstrb <= 4'h0;
    axi_wr(`TW_CTRL_ADDR, 8'h04, 2'b00);
    s_axi_wstrb <= 4'hf;
    axi_wr(`TW_DATA_ADDR, 8'h55, 2'b00);
    axi_rd(`TW_CTRL_ADDR, v, r);
    check(v, 32'h1 << `TW_WC_BIT);
    step(9'h000, 8'ha4, `TW_ST_START, 9'h000);
    step(9'h155, 8'hc4, `TW_ST_AR_ACK, 9'h000);
    step(9'h000, 8'hc4, `TW_ST_RX_ACK, 9'h1c3);
    step(9'h000, 8'h84, `TW_ST_RX_NACK, 9'h1d4);
    step(9'h000, 8'hb4, `TW_ST_START, 9'h000);
    @(posedge aclk);
    stretch_ns <= 12'd1500;
    step(9'h155, 8'h84, `TW_ST_AR_ACK, 9'h000);
    step(9'h000, 8'h84, `TW_ST_RX_NACK, 9'h1c3);
    step(9'h000, 8'ha4, `TW_ST_RSTART, 9'h000);
    step(9'h177, 8'h84, `TW_ST_AR_NACK, 9'h000);
    step(9'h000, 8'ha4, `TW_ST_RSTART, 9'h000);
    step(9'h154, 8'h84, `TW_ST_AW_NACK, 9'h000);
    axi_wr(`TW_CTRL_ADDR, 8'h94, 2'b00);
    poll_ctrl(`TW_STO_BIT, 1'b0, v);
    check(v, 32'h1 << `TW_EN_BIT);
    check({scl_i, sda_i}, 2'b11);
    check({30'h0, scl_o, sda_o}, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
